// [feic_defs.svh]
// Constants for the fault event interrupt controller.
// Summary of operation
// - Mask bit 31 resets to one; no new message is offered while it is set.
// - With mask clear, a detected condition sends data and address as a message.
// - A new primary fault summary sets the read-only pending bit 30.
// - A newly set invalidation queue error also sets the pending bit.
// - Completion error and completion time-out setting are also interrupt conditions.
// - No new condition if any fault status was already set beforehand.
// - Pending stays set while the message is held back by mask or busy fabric.
// - Pending clears when the held message is actually issued.
// - Pending clears without message once every status is serviced while the message is still held.
// - Data register keeps 16 bits in 15:0, resets zero, upper bits read zero.
// - Primary fault summary is the OR of all fault record flags.
// - Message address is bits 31:2 of address register, low bits zero.
`ifndef FEIC_DEFS_SVH
`define FEIC_DEFS_SVH
`define FEIC_NUM_RECORDS     8
`define FEIC_OFF_STATUS      12'h034
`define FEIC_OFF_CONTROL     12'h038
`define FEIC_OFF_DATA        12'h03c
`define FEIC_OFF_ADDRESS     12'h040
`define FEIC_OFF_RECORDS     12'h050
`define FEIC_OFF_IRQ_STATUS  12'h060
`define FEIC_OFF_IRQ_ENABLE  12'h064
`define FEIC_OFF_IRQ_CLEAR   12'h068
`define FEIC_CTL_MASK_BIT    31
`define FEIC_CTL_PEND_BIT    30
`define FEIC_ST_PPF_BIT      1
`define FEIC_ST_IQE_BIT      4
`define FEIC_ST_ICE_BIT      5
`define FEIC_ST_ITE_BIT      6
`define FEIC_CTL_RESET       32'h8000_0000
`define FEIC_DATA_MASK       32'h0000_ffff
`define FEIC_ADDR_MASK       32'hffff_fffc
`define FEIC_W1C_MASK        32'h0000_0070
`endif

// [feic_pkg.sv]
// Types for the fault event interrupt controller.
package feic_pkg;
  typedef enum logic [1:0] {MSG_IDLE, MSG_HELD, MSG_SEND} feic_msg_state_t;
endpackage

// [feic_rise_det.sv]
// Rising edge detector for one status source.
`timescale 1ns/100ps
module feic_rise_det (
  input  wire logic i_clock,  // Clock.
  input  wire logic i_rst_n,  // Asynchronous reset, active low.
  input  wire logic i_level,  // Level to watch.
  output logic      o_rise    // High for one cycle after a rising edge.
);
  logic prev_ff;

  // Previous value, used to spot a zero-to-one step.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= i_level;
    end
  end

  // Combinational edge flag.
  assign o_rise = i_level & ~prev_ff;
endmodule

// [feic_top.sv]
// Fault event interrupt controller with APB registers and message output.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`include "feic_defs.svh"
module feic_top (
  input  wire logic        I_CLOCK,        // 10 MHz clock.
  input  wire logic        I_RST_N,        // Asynchronous reset, active low.
  input  wire logic        I_PSEL,         // APB select.
  input  wire logic        I_PENABLE,      // APB access phase.
  input  wire logic        I_PWRITE,       // APB write.
  input  wire logic [11:0] I_PADDR,        // APB byte address.
  input  wire logic [31:0] I_PWDATA,       // APB write data.
  output logic      [31:0] O_PRDATA,       // APB read data.
  output logic             O_PREADY,       // APB ready.
  output logic             O_PSLVERR,      // APB error for unmapped address.
  input  wire logic [7:0]  I_RECORD_SET,   // Pulse per fault record: fault logged.
  input  wire logic        I_IQE_SET,      // Pulse: invalidation queue error.
  input  wire logic        I_ICE_SET,      // Pulse: invalidation completion error.
  input  wire logic        I_ITE_SET,      // Pulse: invalidation time-out.
  output logic             O_MSG_VALID,    // Interrupt message request.
  input  wire logic        I_MSG_READY,    // Fabric accepts message.
  output logic      [31:0] O_MSG_ADDR,     // Message address.
  output logic      [31:0] O_MSG_DATA,     // Message data.
  output logic             O_IRQ           // Local level interrupt.
);
  // Register state comes first; software sees it through the read mux at the end.
  // The status fields are sticky. Hardware sets them, and software clears them
  // by writing ones back. From their rising edges the engine derives one fresh
  // condition at a time and turns it into a single held or offered message.
  // Hazard: once a message is offered it is never withdrawn. The fabric
  // therefore always sees a complete request, even when software masks the
  // block or services the status in the meantime.
  // Trade-off: every bus access costs one wait state. In return, ready, read
  // data and the error flag all come straight from flip-flops.
  logic [31:0] control_ff;
  logic [15:0] data_ff;
  logic [29:0] addr_ff;
  logic [7:0]  record_ff;
  logic        iqe_ff;
  logic        ice_ff;
  logic        ite_ff;
  logic        pend_ff;
  logic [3:0]  irq_stat_ff;
  logic [3:0]  irq_en_ff;
  logic        any_fault_prev_ff;
  feic_pkg::feic_msg_state_t msg_state_ff;

  // Decoded strobes and combinational helpers.
  logic        wr_en;
  logic        rd_en;
  logic        primary_faults_pending;
  logic        ppf_rise;
  logic        iqe_rise;
  logic        ice_rise;
  logic        ite_rise;
  logic        new_cond;
  logic        all_clear;
  logic [31:0] status_word;
  logic [3:0]  events;
  logic [31:0] nxt_rdata;
  logic        nxt_err;
  logic        wr_status;
  logic        wr_control;
  logic        wr_data;
  logic        wr_addr;
  logic        wr_records;
  logic        wr_irq_en;
  logic        wr_irq_clr;
  logic        any_fault;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: a request is taken once, at the first edge of its access phase.
  // Gating with the registered ready keeps the second access cycle, in which
  // ready stands, from applying a write or a clear a second time.
  assign wr_en = I_PSEL & I_PENABLE & I_PWRITE & ~O_PREADY;
  assign rd_en = I_PSEL & I_PENABLE & ~I_PWRITE & ~O_PREADY;

  // One write strobe per register. An unmapped offset raises none of them, so a
  // stray write changes no state.
  assign wr_status  = wr_en & (I_PADDR == `FEIC_OFF_STATUS);
  assign wr_control = wr_en & (I_PADDR == `FEIC_OFF_CONTROL);
  assign wr_data    = wr_en & (I_PADDR == `FEIC_OFF_DATA);
  assign wr_addr    = wr_en & (I_PADDR == `FEIC_OFF_ADDRESS);
  assign wr_records = wr_en & (I_PADDR == `FEIC_OFF_RECORDS);
  assign wr_irq_en  = wr_en & (I_PADDR == `FEIC_OFF_IRQ_ENABLE);
  assign wr_irq_clr = wr_en & (I_PADDR == `FEIC_OFF_IRQ_CLEAR);

  // Summary of fault records and the status word.
  assign primary_faults_pending = |record_ff;
  assign status_word = {25'h0, ite_ff, ice_ff, iqe_ff, 2'h0, primary_faults_pending, 1'b0};

  // Any status field still set. Reserved status bits always read zero.
  assign any_fault = primary_faults_pending | iqe_ff | ice_ff | ite_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Fault record flags: hardware set wins over a software clear in the same cycle.
  // A fault that lands during the service write is therefore never lost.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      record_ff <= 8'h00;
    end else if (wr_records) begin
      record_ff <= (record_ff & ~I_PWDATA[7:0]) | I_RECORD_SET;
    end else begin
      record_ff <= record_ff | I_RECORD_SET;
    end
  end

  // Other status fields, write-one-to-clear with set priority.
  // Software writes back what it read, so only the ones that it saw are cleared.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      iqe_ff <= 1'b0;
      ice_ff <= 1'b0;
      ite_ff <= 1'b0;
    end else if (wr_status) begin
      iqe_ff <= (iqe_ff & ~I_PWDATA[`FEIC_ST_IQE_BIT]) | I_IQE_SET;
      ice_ff <= (ice_ff & ~I_PWDATA[`FEIC_ST_ICE_BIT]) | I_ICE_SET;
      ite_ff <= (ite_ff & ~I_PWDATA[`FEIC_ST_ITE_BIT]) | I_ITE_SET;
    end else begin
      iqe_ff <= iqe_ff | I_IQE_SET;
      ice_ff <= ice_ff | I_ICE_SET;
      ite_ff <= ite_ff | I_ITE_SET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One edge detector per status source.
  // Each detector resets low, the idle level of its source, so the release of
  // reset never looks like a fresh fault.
  feic_rise_det u_ppf (.i_clock(I_CLOCK), .i_rst_n(I_RST_N), .i_level(primary_faults_pending),
                       .o_rise(ppf_rise));
  feic_rise_det u_iqe (.i_clock(I_CLOCK), .i_rst_n(I_RST_N), .i_level(iqe_ff),
                       .o_rise(iqe_rise));
  feic_rise_det u_ice (.i_clock(I_CLOCK), .i_rst_n(I_RST_N), .i_level(ice_ff),
                       .o_rise(ice_rise));
  feic_rise_det u_ite (.i_clock(I_CLOCK), .i_rst_n(I_RST_N), .i_level(ite_ff),
                       .o_rise(ite_rise));

  // Previous any-fault level; a rise while another field was set is no new condition.
  // The level of the cycle before is used. Two sources that rise together
  // therefore still count as one fresh condition.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      any_fault_prev_ff <= 1'b0;
    end else begin
      any_fault_prev_ff <= any_fault;
    end
  end

  // Edge pulses of the four sources and the combined fresh condition.
  assign events   = {ite_rise, ice_rise, iqe_rise, ppf_rise};
  assign new_cond = (|events) & ~any_fault_prev_ff;
  // All serviced: nothing is left that could justify a held message.
  assign all_clear = ~any_fault;

  ////////////////////////////////////////////////////////////////////////////
  // Control register; bits 29:0 are plain storage and drive nothing.
  // The pending bit lives in the engine, so a bus write can never touch it.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      control_ff <= `FEIC_CTL_RESET;
    end else if (wr_control) begin
      control_ff <= {I_PWDATA[31], 1'b0, I_PWDATA[29:0]};
    end
  end

  // Message data: only the low half is stored, so the upper half reads zero.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      data_ff <= 16'h0000;
    end else if (wr_data) begin
      data_ff <= I_PWDATA[15:0];
    end
  end

  // Message address: the two low bits are never stored, so it stays word aligned.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      addr_ff <= 30'h0;
    end else if (wr_addr) begin
      addr_ff <= I_PWDATA[31:2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message engine: held while masked or while the fabric stalls.
  // Idle waits for a fresh condition. Held waits for the mask to open, or for
  // software to service every status. Send waits for the fabric to accept.
  // Limitation: conditions that arrive in held or send are absorbed, not queued.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      msg_state_ff <= feic_pkg::MSG_IDLE;
      pend_ff      <= 1'b0;
      O_MSG_VALID  <= 1'b0;
      O_MSG_ADDR   <= 32'h0;
      O_MSG_DATA   <= 32'h0;
    end else begin
      unique case (msg_state_ff)
        feic_pkg::MSG_IDLE: begin
          if (new_cond) begin
            pend_ff      <= 1'b1;
            msg_state_ff <= feic_pkg::MSG_HELD;
          end
        end
        feic_pkg::MSG_HELD: begin
          if (all_clear) begin
            pend_ff      <= 1'b0;
            msg_state_ff <= feic_pkg::MSG_IDLE;
          end else if (!control_ff[`FEIC_CTL_MASK_BIT]) begin
            O_MSG_VALID  <= 1'b1;
            O_MSG_ADDR   <= {addr_ff, 2'b00};
            O_MSG_DATA   <= {16'h0, data_ff};
            msg_state_ff <= feic_pkg::MSG_SEND;
          end
        end
        feic_pkg::MSG_SEND: begin
          // Once offered, the message is not withdrawn; pending stays set meanwhile.
          if (I_MSG_READY) begin
            O_MSG_VALID  <= 1'b0;
            pend_ff      <= 1'b0;
            msg_state_ff <= feic_pkg::MSG_IDLE;
          end
        end
        default: msg_state_ff <= feic_pkg::MSG_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local interrupt status: one sticky bit per source edge; writing ones clears it.
  // An edge in the cycle of the clear wins, so no event slips past software.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_stat_ff <= 4'h0;
    end else if (wr_irq_clr) begin
      irq_stat_ff <= (irq_stat_ff & ~I_PWDATA[3:0]) | events;
    end else begin
      irq_stat_ff <= irq_stat_ff | events;
    end
  end

  // Local interrupt enable, with the same layout as the status.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_en_ff <= 4'h0;
    end else if (wr_irq_en) begin
      irq_en_ff <= I_PWDATA[3:0];
    end
  end

  // Level interrupt, registered so that the pin comes straight from a flip-flop.
  // It follows status and enable one cycle late.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(irq_stat_ff & irq_en_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and unmapped-address error.
  // Write-only and unmapped offsets read as zero; only unmapped ones flag an error.
  always_comb begin
    nxt_rdata = 32'h0;
    nxt_err   = 1'b0;
    unique case (I_PADDR)
      `FEIC_OFF_STATUS:     nxt_rdata = status_word;
      `FEIC_OFF_CONTROL:    nxt_rdata = {control_ff[31], pend_ff, control_ff[29:0]};
      `FEIC_OFF_DATA:       nxt_rdata = {16'h0, data_ff};
      `FEIC_OFF_ADDRESS:    nxt_rdata = {addr_ff, 2'b00};
      `FEIC_OFF_RECORDS:    nxt_rdata = {24'h0, record_ff};
      `FEIC_OFF_IRQ_STATUS: nxt_rdata = {28'h0, irq_stat_ff};
      `FEIC_OFF_IRQ_ENABLE: nxt_rdata = {28'h0, irq_en_ff};
      `FEIC_OFF_IRQ_CLEAR:  nxt_rdata = 32'h0;
      default:              nxt_err   = 1'b1;
    endcase
  end

  // Ready rises one cycle into the access phase, registered.
  // It stands for a single cycle, which closes the access phase.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PREADY <= 1'b0;
    end else begin
      O_PREADY <= I_PSEL & I_PENABLE & ~O_PREADY;
    end
  end

  // The error answer stands together with ready, and only for unmapped offsets.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PSLVERR <= 1'b0;
    end else begin
      O_PSLVERR <= I_PSEL & I_PENABLE & ~O_PREADY & nxt_err;
    end
  end

  // Read data is valid with ready and is zero otherwise, so the bus shows no stale data.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PRDATA <= 32'h0;
    end else begin
      O_PRDATA <= rd_en ? nxt_rdata : 32'h0;
    end
  end
endmodule

// [feic_fabric_model.sv]
// Behavioural interrupt fabric that accepts message requests.
`timescale 1ns/100ps
module feic_fabric_model (
  input  wire logic       i_clock,  // Clock.
  input  wire logic       i_rst_n,  // Reset, active low.
  input  wire logic       i_valid,  // Message request.
  input  wire logic [1:0] i_lat,    // Stall before accepting: this many cycles plus one.
  output logic            o_ready   // Accept, one cycle.
);
  logic [1:0] wait_ff;
  // Stall for i_lat plus one cycles so both prompt and slow acceptance occur.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_ff <= 2'h0;
      o_ready <= 1'b0;
    end else if (o_ready || !i_valid) begin
      wait_ff <= 2'h0;
      o_ready <= 1'b0;
    end else if (wait_ff == i_lat) o_ready <= 1'b1;
    else wait_ff <= wait_ff + 2'h1;
  end
endmodule

// [feic_top_monitor.sv]
// Concurrent checks on the ports of the fault event interrupt controller.
`timescale 1ns/100ps
module feic_top_monitor (
  input wire logic        I_CLOCK,       // Clock.
  input wire logic        I_RST_N,       // Reset, active low.
  input wire logic        I_PSEL,        // Bus select.
  input wire logic        I_PENABLE,     // Bus access phase.
  input wire logic        I_PWRITE,      // Bus direction.
  input wire logic [11:0] I_PADDR,       // Bus address.
  input wire logic [31:0] I_PWDATA,      // Bus write data.
  input wire logic [31:0] O_PRDATA,      // Bus read data.
  input wire logic [31:0] O_MSG_ADDR,    // Message address.
  input wire logic [31:0] O_MSG_DATA,    // Message data.
  input wire logic        O_PREADY,      // Bus ready.
  input wire logic        O_PSLVERR,     // Bus error.
  input wire logic        I_IQE_SET,     // Queue error pulse.
  input wire logic        I_ICE_SET,     // Completion error pulse.
  input wire logic        I_ITE_SET,     // Time-out pulse.
  input wire logic        O_MSG_VALID,   // Message request.
  input wire logic        I_MSG_READY,   // Message accept.
  input wire logic [7:0]  I_RECORD_SET   // Fault record set pulses.
);
  logic mask_ff, ev_ff;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  // Shadow of the mask and of any event since the last accepted message.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mask_ff <= 1'b1;
      ev_ff <= 1'b0;
    end else begin
      if (I_PSEL && I_PENABLE && I_PWRITE && !O_PREADY && I_PADDR == 12'h038)
        mask_ff <= I_PWDATA[31];
      if (|{I_RECORD_SET, I_IQE_SET, I_ICE_SET, I_ITE_SET}) ev_ff <= 1'b1;
      else if (O_MSG_VALID && I_MSG_READY) ev_ff <= 1'b0;
    end
  end
  AST_MASKED_QUIET: assert property ($rose(O_MSG_VALID) |-> !$past(mask_ff))
    else $error("message raised while masked");
  AST_MSG_HOLD: assert property (O_MSG_VALID && !I_MSG_READY |=> O_MSG_VALID
    && $stable(O_MSG_ADDR) && $stable(O_MSG_DATA)) else $error("message not held");
  AST_MSG_FORM: assert property (O_MSG_VALID |-> O_MSG_ADDR[1:0] == 2'h0
    && O_MSG_DATA[31:16] == 16'h0) else $error("message malformed");
  AST_MSG_DONE: assert property (O_MSG_VALID && I_MSG_READY |=> !O_MSG_VALID)
    else $error("message not retired");
  AST_MSG_CAUSE: assert property ($rose(O_MSG_VALID) |-> ev_ff)
    else $error("message without event");
  AST_APB_ANSWER: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
    else $error("no bus answer");
  AST_DATA_UPPER: assert property (O_PREADY && !I_PWRITE && I_PADDR == 12'h03c
    |-> O_PRDATA[31:16] == 16'h0) else $error("data upper bits set");
  AST_SLVERR_ZERO: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0)
    else $error("error answer not clean");
endmodule
bind feic_top feic_top_monitor u_mon (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_MSG_ADDR(O_MSG_ADDR),
  .O_MSG_DATA(O_MSG_DATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .I_IQE_SET(I_IQE_SET), .I_ICE_SET(I_ICE_SET), .I_ITE_SET(I_ITE_SET),
  .O_MSG_VALID(O_MSG_VALID), .I_MSG_READY(I_MSG_READY), .I_RECORD_SET(I_RECORD_SET));

// [fault_event_interrupt_ctl_tb.sv]
// Self-checking bench for the fault event interrupt controller.
`timescale 1ns/100ps
module fault_event_interrupt_ctl_tb;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, rdy;
  logic        pready, pslverr, mvalid, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, maddr, mdata, a, d;
  logic [10:0] sets = 0;
  logic [1:0]  lat = 0;
  logic [15:0] r = 16'he9bd;
  logic [63:0] rq[$], mq[$];
  int          errors = 0, checked = 0;
  int          ks[4] = '{9, 10, 3, 7};
  always #50 clk = ~clk;
  feic_top dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RECORD_SET(sets[7:0]),
    .I_IQE_SET(sets[8]), .I_ICE_SET(sets[9]), .I_ITE_SET(sets[10]),
    .O_MSG_VALID(mvalid), .I_MSG_READY(rdy), .O_MSG_ADDR(maddr), .O_MSG_DATA(mdata),
    .O_IRQ(irq));
  feic_fabric_model fab (.i_clock(clk), .i_rst_n(rst_n), .i_valid(mvalid), .i_lat(lat),
    .o_ready(rdy));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize;
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One bus transfer; the request is held until ready is seen at an edge.
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
                     input logic [63:0] e);
    if (!w) rq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd, 64'h0);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [63:0] e);
    apb(1'b0, ad, 32'h0, e);
  endtask
  // One-cycle pulse on a source: 0..7 records, 8 queue, 9 completion, 10 time-out.
  task automatic ev(input int k);
    sets <= 11'h1 << k;
    @(posedge clk) sets <= 11'h0;
    repeat (4) @(posedge clk);
  endtask
  // Results are matched to the oldest note; an unexpected result meets x.
  always @(posedge clk) begin
    if (pready && !pwrite) chk({pslverr, prdata}, rq.size() ? rq.pop_front() : 'x);
    if (mvalid && rdy) chk({maddr, mdata}, mq.size() ? mq.pop_front() : 'x);
  end
  initial begin
    #400000;
    errors++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(12'h038, 64'h8000_0000);
    rd(12'h03c, 64'h0);
    r = lfsr(r);
    d = {~r, r};
    wr(12'h03c, d);
    rd(12'h03c, {48'h0, r});
    r = lfsr(r);
    a = {r, ~r};
    wr(12'h040, a);
    rd(12'h040, {32'h0, a & 32'hffff_fffc});
    rd(12'h100, {31'h0, 1'b1, 32'h0});
    wr(12'h038, 32'hffff_ffff);
    rd(12'h038, 64'hbfff_ffff);
    ev(8);
    rd(12'h038, 64'hffff_ffff);
    rd(12'h034, 64'h10);
    mq.push_back({a & 32'hffff_fffc, 16'h0, d[15:0]});
    lat <= 2'h3;
    wr(12'h038, 32'h0);
    repeat (10) @(posedge clk);
    rd(12'h038, 64'h0);
    wr(12'h034, 32'h10);
    foreach (ks[i]) begin
      lat <= r[1:0];
      r = lfsr(r);
      mq.push_back({a & 32'hffff_fffc, 16'h0, d[15:0]});
      ev(ks[i]);
      repeat (6) @(posedge clk);
      wr(ks[i] < 8 ? 12'h050 : 12'h034, 32'h1 << (ks[i] < 8 ? ks[i] : ks[i] - 4));
    end
    mq.push_back({a & 32'hffff_fffc, 16'h0, d[15:0]});
    ev(9);
    ev(10);
    repeat (6) @(posedge clk);
    wr(12'h034, 32'h60);
    wr(12'h038, 32'h8000_0000);
    wr(12'h068, 32'hf);
    wr(12'h064, 32'h8);
    ev(10);
    chk(irq, 64'h1);
    wr(12'h068, 32'h8);
    chk(irq, 64'h0);
    wr(12'h064, 32'h0);
    wr(12'h034, 32'h40);
    ev(10);
    chk(irq, 64'h0);
    rd(12'h060, 64'h8);
    wr(12'h068, 32'h8);
    rd(12'h038, 64'hc000_0000);
    wr(12'h034, 32'h40);
    rd(12'h038, 64'h8000_0000);
    ev(5);
    rd(12'h038, 64'hc000_0000);
    rd(12'h050, 64'h20);
    rd(12'h034, 64'h2);
    wr(12'h050, 32'h20);
    rd(12'h038, 64'h8000_0000);
    wr(12'h038, 32'h0);
    repeat (8) @(posedge clk);
    chk(mq.size() + rq.size(), 64'h0);
    summarize();
  end
endmodule
